/* rtl/cmpc_defs.svh */
// Purpose: constants for the converter mode and pin control block
// Assumes: one clock at 50 MHz
// Notes: offsets are indices of the serial configuration space
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH
`define CMPC_CLK_PERIOD_NS 20
`define CMPC_ADDR_CONFIG 4'h0
`define CMPC_ADDR_RANGE_I 4'h3
`define CMPC_ADDR_RANGE_Q 4'hB
`define CMPC_BIT_CAL 15
`define CMPC_BIT_PHASE 14
`define CMPC_BIT_INTERLEAVE 7
`define CMPC_BIT_QUAD 6
`define CMPC_CONFIG_RESET 16'h0000
`define CMPC_RANGE_MIN 16'h0000
`define CMPC_RANGE_MID 16'h8000
`define CMPC_RANGE_RESET 16'h8000
`define CMPC_CAL_LOW_NS 1280
`define CMPC_CAL_HIGH_NS 1280
`define CMPC_CAL_RUN_NS 20000
`endif

/* rtl/cmpc_mode_ctrl.sv */
// Purpose: mode pins, extended control registers and calibration sequencing
// Assumes: pins asynchronous to mclk_i; register port on mclk_i
// Notes: serial protocol lives outside; this block sees a plain register port
`timescale 1ns/1ns
`include "cmpc_defs.svh"
module cmpc_mode_ctrl #(
  parameter int CAL_RUN_CYCLES = (`CMPC_CAL_RUN_NS + `CMPC_CLK_PERIOD_NS - 1) / `CMPC_CLK_PERIOD_NS,
  parameter int RANGE_WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Control pins from the host
  input wire logic calibration_request_i,
  input wire logic output_phase_select_i,
  input wire logic interleave_select_i,
  input wire logic extended_control_enable_n_i,
  input wire logic full_scale_range_select_i,
  input wire logic non_demux_select_i,
  // Register port, serial side already decoded
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  // Resolved settings
  output logic calibration_active_o,
  output logic extended_control_mode_o,
  output logic non_demux_o,
  output logic phase_valid_o,
  output logic output_phase_o,
  output logic interleave_o,
  output logic convert_quad_input_o,
  output logic [RANGE_WIDTH-1:0] range_in_phase_o,
  output logic [RANGE_WIDTH-1:0] range_quadrature_o
);
  localparam int CAL_LOW_CYCLES = (`CMPC_CAL_LOW_NS + `CMPC_CLK_PERIOD_NS - 1) / `CMPC_CLK_PERIOD_NS;
  localparam int CAL_HIGH_CYCLES = (`CMPC_CAL_HIGH_NS + `CMPC_CLK_PERIOD_NS - 1) / `CMPC_CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // Elaboration checks
  if (CAL_RUN_CYCLES < 1 || CAL_RUN_CYCLES >= (1 << CNT_W))
  begin : g_bad_run
    $error("CAL_RUN_CYCLES out of range");
  end
  if (RANGE_WIDTH != 16)
  begin : g_bad_range
    $error("RANGE_WIDTH must be 16");
  end

  logic [5:0] pins_sync;
  logic cal_pin_s;
  logic phase_pin_s;
  logic ilv_pin_s;
  logic range_pin_s;
  logic nondemux_pin_s;
  // High while the register port owns the settings
  logic ext_mode;
  logic [15:0] config_reg;
  logic [15:0] range_i_reg;
  logic [15:0] range_q_reg;
  logic cal_combined;
  cmpc_pkg::cmpc_cal_state_type cal_state_reg;
  logic [CNT_W-1:0] cal_cnt_reg;

  // Pin synchronisers
  // Enable goes in inverted: cleared flops then mean pin mode, not a false extended mode
  cmpc_sync #(
    .WIDTH(6)
  ) u_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .async_i({calibration_request_i, output_phase_select_i, interleave_select_i,
              !extended_control_enable_n_i, full_scale_range_select_i, non_demux_select_i}),
    .sync_o(pins_sync)
  );

  assign cal_pin_s = pins_sync[5];
  assign phase_pin_s = pins_sync[4];
  assign ilv_pin_s = pins_sync[3];
  assign range_pin_s = pins_sync[1];
  assign nondemux_pin_s = pins_sync[0];

  assign ext_mode = pins_sync[2];

  // Address decode shared by write and read
  function automatic logic [1:0] cmpc_decode(input logic [3:0] addr);
    case (addr)
      `CMPC_ADDR_CONFIG: cmpc_decode = 2'h1;
      `CMPC_ADDR_RANGE_I: cmpc_decode = 2'h2;
      `CMPC_ADDR_RANGE_Q: cmpc_decode = 2'h3;
      default: cmpc_decode = 2'h0;
    endcase
  endfunction : cmpc_decode

  // Registers held at defaults outside extended mode
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      config_reg <= `CMPC_CONFIG_RESET;
      range_i_reg <= `CMPC_RANGE_RESET;
      range_q_reg <= `CMPC_RANGE_RESET;
    end
    else if (!ext_mode)
    begin
      // Written settings are lost as soon as the port closes
      config_reg <= `CMPC_CONFIG_RESET;
      range_i_reg <= `CMPC_RANGE_RESET;
      range_q_reg <= `CMPC_RANGE_RESET;
    end
    else if (reg_write_i)
    begin
      case (cmpc_decode(reg_addr_i))
        2'h1: config_reg <= reg_wdata_i;
        2'h2: range_i_reg <= reg_wdata_i;
        2'h3: range_q_reg <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; port dead outside extended mode
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_rdata_o <= 16'h0000;
    end
    else if (reg_read_i && ext_mode)
    begin
      case (cmpc_decode(reg_addr_i))
        2'h1: reg_rdata_o <= config_reg;
        2'h2: reg_rdata_o <= range_i_reg;
        2'h3: reg_rdata_o <= range_q_reg;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
    else
    begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // Pin ORed with config bit in extended mode
  // Bit is a level: software clears it before it can ask again
  assign cal_combined = cal_pin_s | (ext_mode & config_reg[`CMPC_BIT_CAL]);

  // Low then high qualification; one run per qualified rise
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cal_state_reg <= cmpc_pkg::CAL_WAIT_LOW;
      cal_cnt_reg <= 16'h0000;
    end
    else
    begin
      case (cal_state_reg)
        cmpc_pkg::CAL_WAIT_LOW:
        begin
          // Low time counted; any high restarts the count
          if (cal_combined)
          begin
            cal_cnt_reg <= 16'h0000;
          end
          else if (cal_cnt_reg >= CNT_W'(CAL_LOW_CYCLES - 1))
          begin
            cal_cnt_reg <= 16'h0000;
            cal_state_reg <= cmpc_pkg::CAL_ARMED;
          end
          else
          begin
            cal_cnt_reg <= cal_cnt_reg + 16'h0001;
          end
        end
        cmpc_pkg::CAL_ARMED:
        begin
          if (cal_combined)
          begin
            cal_cnt_reg <= 16'h0001;
            cal_state_reg <= cmpc_pkg::CAL_WAIT_HIGH;
          end
        end
        cmpc_pkg::CAL_WAIT_HIGH:
        begin
          // A glitch high too short falls back to needing a fresh low
          if (!cal_combined)
          begin
            cal_cnt_reg <= 16'h0000;
            cal_state_reg <= cmpc_pkg::CAL_WAIT_LOW;
          end
          else if (cal_cnt_reg >= CNT_W'(CAL_HIGH_CYCLES))
          begin
            cal_cnt_reg <= 16'h0000;
            cal_state_reg <= cmpc_pkg::CAL_RUN;
          end
          else
          begin
            cal_cnt_reg <= cal_cnt_reg + 16'h0001;
          end
        end
        cmpc_pkg::CAL_RUN:
        begin
          // Request level ignored while running; a new low is needed later
          if (cal_cnt_reg >= CNT_W'(CAL_RUN_CYCLES - 1))
          begin
            cal_cnt_reg <= 16'h0000;
            cal_state_reg <= cmpc_pkg::CAL_WAIT_LOW;
          end
          else
          begin
            cal_cnt_reg <= cal_cnt_reg + 16'h0001;
          end
        end
        default:
        begin
          cal_cnt_reg <= 16'h0000;
          cal_state_reg <= cmpc_pkg::CAL_WAIT_LOW;
        end
      endcase
    end
  end

  // Active flag follows the run state
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      calibration_active_o <= 1'b0;
    end
    else
    begin
      calibration_active_o <= (cal_state_reg == cmpc_pkg::CAL_WAIT_HIGH &&
                               cal_combined && cal_cnt_reg >= CNT_W'(CAL_HIGH_CYCLES)) ||
                              (cal_state_reg == cmpc_pkg::CAL_RUN &&
                               cal_cnt_reg < CNT_W'(CAL_RUN_CYCLES - 1));
    end
  end

  // Resolved output settings, registered
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      extended_control_mode_o <= 1'b0;
      non_demux_o <= 1'b0;
      phase_valid_o <= 1'b0;
      output_phase_o <= 1'b0;
      interleave_o <= 1'b0;
      convert_quad_input_o <= 1'b0;
      range_in_phase_o <= `CMPC_RANGE_MIN;
      range_quadrature_o <= `CMPC_RANGE_MIN;
    end
    else
    begin
      extended_control_mode_o <= ext_mode;
      non_demux_o <= nondemux_pin_s;
      phase_valid_o <= !nondemux_pin_s;
      // Register bit in extended mode
      // Forced low in 1:1 so no stale phase leaks out
      output_phase_o <= !nondemux_pin_s && (ext_mode ? config_reg[`CMPC_BIT_PHASE] : phase_pin_s);
      interleave_o <= ext_mode ? config_reg[`CMPC_BIT_INTERLEAVE] : ilv_pin_s;
      convert_quad_input_o <= ext_mode && config_reg[`CMPC_BIT_INTERLEAVE] && config_reg[`CMPC_BIT_QUAD];
      // Pin high is mid, pin low is minimum
      range_in_phase_o <= ext_mode ? range_i_reg : (range_pin_s ? `CMPC_RANGE_MID : `CMPC_RANGE_MIN);
      range_quadrature_o <= ext_mode ? range_q_reg : (range_pin_s ? `CMPC_RANGE_MID : `CMPC_RANGE_MIN);
    end
  end
endmodule : cmpc_mode_ctrl

/* rtl/cmpc_pkg.sv */
// Purpose: types shared by the mode control block
// Assumes: nothing
// Notes: states only; numbers live in the header
package cmpc_pkg;
  typedef enum logic [1:0] {CAL_WAIT_LOW, CAL_ARMED, CAL_WAIT_HIGH, CAL_RUN} cmpc_cal_state_type;
endpackage : cmpc_pkg

/* rtl/cmpc_sync.sv */
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module cmpc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1_reg;

  // Two stages against metastability
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage1_reg <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1_reg <= async_i;
      sync_o <= stage1_reg;
    end
  end
endmodule : cmpc_sync

/* testbench/cmpc_host_model.sv */
// Purpose: host side driving the calibration request pin
// Assumes: one go pulse starts a low then high sequence
// Notes: after the sequence the pin parks at the idle level
`timescale 1ns/1ns
module cmpc_host_model (
  // Clock
  input wire logic mclk_i,
  // Commands
  input wire logic go_i,
  input wire logic [7:0] high_len_i,
  input wire logic idle_level_i,
  // Pin
  output logic calibration_request_o
);
  logic [7:0] step_reg = 8'hFF;
  // Step counter, parked at the top
  always @(posedge mclk_i)
  begin
    if (go_i)
      step_reg <= 8'h00;
    else if (step_reg != 8'hFF)
      step_reg <= step_reg + 8'h01;
  end
  assign calibration_request_o = (step_reg < 8'h46) ? 1'b0 :
    (step_reg < 8'h46 + high_len_i) ? 1'b1 : idle_level_i;
endmodule : cmpc_host_model

/* testbench/cmpc_mode_ctrl_properties.sv */
// Purpose: port-level properties of the mode control block
// Assumes: bound into cmpc_mode_ctrl, pins held steady across reset
// Notes: counters stand in for long repetitions
`timescale 1ns/1ns
module cmpc_mode_ctrl_properties #(
  parameter int CAL_RUN_CYCLES = 1000
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Watched inputs
  input wire logic calibration_request_i,
  input wire logic extended_control_enable_n_i,
  input wire logic non_demux_select_i,
  input wire logic reg_read_i,
  // Watched outputs
  input wire logic [15:0] reg_rdata_o,
  input wire logic calibration_active_o,
  input wire logic extended_control_mode_o,
  input wire logic non_demux_o,
  input wire logic phase_valid_o,
  input wire logic output_phase_o,
  input wire logic interleave_o,
  input wire logic convert_quad_input_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  logic [15:0] run_cnt_reg;
  logic [15:0] req_hi_reg;
  // Length of the current run
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      run_cnt_reg <= 16'h0000;
    else
      run_cnt_reg <= calibration_active_o ? run_cnt_reg + 16'h0001 : 16'h0000;
  end
  // Raw pin high time, no sync delay removed
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      req_hi_reg <= 16'h0000;
    else
      req_hi_reg <= !calibration_request_i ? 16'h0000 :
                    (req_hi_reg == 16'hFFFF) ? req_hi_reg : req_hi_reg + 16'h0001;
  end
  sequence s_run_start;
    $rose(calibration_active_o) && !extended_control_mode_o;
  endsequence
  sequence s_run_end;
    $fell(calibration_active_o);
  endsequence
  property p_run_len;
    s_run_end |-> run_cnt_reg == CAL_RUN_CYCLES;
  endproperty
  a_run_len: assert property (p_run_len) else $error("run length wrong");
  property p_arm;
    s_run_start |-> req_hi_reg >= 16'h0040;
  endproperty
  a_arm: assert property (p_arm) else $error("run without long high");
  property p_rd_idle;
    !$past(reg_read_i) |-> reg_rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_rd_off;
    $past(reg_read_i) && !extended_control_mode_o |-> reg_rdata_o == 16'h0000;
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("read answered outside mode");
  property p_ndm;
    $past(arst_n_i, 3) |-> non_demux_o == $past(non_demux_select_i, 3);
  endproperty
  a_ndm: assert property (p_ndm) else $error("bus mode lag wrong");
  property p_ecm;
    $past(arst_n_i, 3) |-> extended_control_mode_o == !$past(extended_control_enable_n_i, 3);
  endproperty
  a_ecm: assert property (p_ecm) else $error("mode lag wrong");
  property p_phase;
    non_demux_o |-> !output_phase_o && !phase_valid_o;
  endproperty
  a_phase: assert property (p_phase) else $error("phase active in 1:1");
  property p_quad;
    convert_quad_input_o |-> interleave_o && extended_control_mode_o;
  endproperty
  a_quad: assert property (p_quad) else $error("quad input without interleave");
endmodule : cmpc_mode_ctrl_properties

/* testbench/tb_top.sv */
// Purpose: directed bench for the mode control block
// Assumes: run length shortened to 10 cycles
// Notes: pins change at rising edges, results read at falling edges
`timescale 1ns/1ns
module tb_top;
  logic mclk_i = 1'b0, arst_n_i = 1'b0, calibration_request_i, output_phase_select_i = 1'b0;
  logic interleave_select_i = 1'b0, extended_control_enable_n_i = 1'b1, full_scale_range_select_i = 1'b1;
  logic non_demux_select_i = 1'b0, reg_write_i = 1'b0, reg_read_i = 1'b0, cal_go = 1'b0, cal_idle = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, range_in_phase_o, range_quadrature_o;
  logic [7:0] cal_high_len = 8'h64;
  logic calibration_active_o, extended_control_mode_o, non_demux_o, phase_valid_o;
  logic output_phase_o, interleave_o, convert_quad_input_o;
  int n_fail = 0, samples_checked = 0, hi;
  cmpc_mode_ctrl #(.CAL_RUN_CYCLES(10)) uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .calibration_request_i(calibration_request_i), .output_phase_select_i(output_phase_select_i),
    .interleave_select_i(interleave_select_i), .extended_control_enable_n_i(extended_control_enable_n_i),
    .full_scale_range_select_i(full_scale_range_select_i), .non_demux_select_i(non_demux_select_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .calibration_active_o(calibration_active_o),
    .extended_control_mode_o(extended_control_mode_o), .non_demux_o(non_demux_o), .phase_valid_o(phase_valid_o),
    .output_phase_o(output_phase_o), .interleave_o(interleave_o), .convert_quad_input_o(convert_quad_input_o),
    .range_in_phase_o(range_in_phase_o), .range_quadrature_o(range_quadrature_o));
  cmpc_host_model host (.mclk_i(mclk_i), .go_i(cal_go), .high_len_i(cal_high_len),
    .idle_level_i(cal_idle), .calibration_request_o(calibration_request_i));
  initial forever #10 mclk_i = ~mclk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge mclk_i);
    reg_write_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge mclk_i);
    reg_read_i <= 1'b0;
    @(negedge mclk_i);
    chk(reg_rdata_o, exp);
  endtask : rd
  // Pulse go, count sampled run cycles in a window
  task automatic cal_run(input int lim, output int n);
    n = 0;
    @(posedge mclk_i);
    cal_go <= 1'b1;
    @(posedge mclk_i);
    cal_go <= 1'b0;
    repeat (lim) @(negedge mclk_i) if (calibration_active_o === 1'b1) n++;
  endtask : cal_run
  task automatic end_sim();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    #100000;
    n_fail++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    // Every combination of the interleave, range, phase and non-demux pins in pin mode
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk_i);
      {interleave_select_i, full_scale_range_select_i, output_phase_select_i, non_demux_select_i} <= i[3:0];
      repeat (4) @(posedge mclk_i);
      @(negedge mclk_i);
      chk(output_phase_o, i[1] && !i[0]);
      chk(phase_valid_o, !i[0]);
      chk(non_demux_o, i[0]);
      chk(interleave_o, i[3]);
      chk(range_in_phase_o, i[2] ? 16'h8000 : 16'h0000);
      chk(range_quadrature_o, i[2] ? 16'h8000 : 16'h0000);
    end
    cal_run(400, hi);
    chk(hi, 10);
    @(posedge mclk_i);
    cal_idle <= 1'b0;
    cal_high_len <= 8'h1E;
    cal_run(300, hi);
    chk(hi, 0);
    // Back to 1:2 demux so the phase setting is visible in extended mode
    @(posedge mclk_i);
    non_demux_select_i <= 1'b0;
    extended_control_enable_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(extended_control_mode_o, 1);
    chk(output_phase_o, 0);
    chk(interleave_o, 0);
    rd(4'h0, 16'h0000);
    wr(4'h0, 16'h40C0);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({output_phase_o, interleave_o, convert_quad_input_o}, 3'b111);
    rd(4'h0, 16'h40C0);
    wr(4'h3, 16'h1234);
    wr(4'hB, 16'hABCD);
    rd(4'h3, 16'h1234);
    rd(4'hB, 16'hABCD);
    chk(range_in_phase_o, 16'h1234);
    chk(range_quadrature_o, 16'hABCD);
    rd(4'h5, 16'h0000);
    // Quadrature choice needs the interleave bit too
    wr(4'h0, 16'h0040);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({interleave_o, convert_quad_input_o}, 2'b00);
    // Bit raises the request while the pin stays low
    hi = 0;
    wr(4'h0, 16'hC0C0);
    repeat (200) @(negedge mclk_i) if (calibration_active_o === 1'b1) hi++;
    chk(hi, 10);
    @(posedge mclk_i);
    extended_control_enable_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(extended_control_mode_o, 0);
    chk(range_quadrature_o, 16'h8000);
    rd(4'h0, 16'h0000);
    @(posedge mclk_i);
    extended_control_enable_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rd(4'h0, 16'h0000);
    rd(4'h3, 16'h8000);
    end_sim();
  end
endmodule : tb_top
bind cmpc_mode_ctrl cmpc_mode_ctrl_properties #(.CAL_RUN_CYCLES(CAL_RUN_CYCLES)) u_props (.mclk_i(mclk_i),
  .arst_n_i(arst_n_i), .calibration_request_i(calibration_request_i),
  .extended_control_enable_n_i(extended_control_enable_n_i), .non_demux_select_i(non_demux_select_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .calibration_active_o(calibration_active_o),
  .extended_control_mode_o(extended_control_mode_o), .non_demux_o(non_demux_o), .phase_valid_o(phase_valid_o),
  .output_phase_o(output_phase_o), .interleave_o(interleave_o), .convert_quad_input_o(convert_quad_input_o));
